//--- logic/ssp_pkg.sv
// Constants, register map and state types for the dual serial port pin block.
// Assumes an AXI4-Lite master on clk and a free running link clock.
package ssp_pkg;
  // ==========================================================================
  // Geometry
  localparam int         NPORT = 2;
  localparam int         NPIN  = 6;
  localparam int         NLANE = 3;
  localparam logic [3:0] WORD  = 4'h8;
  localparam logic [3:0] LAST  = 4'h1;
  // Internal frame sync marks the last bit of each eight bit frame
  localparam logic [2:0] LBC_LAST = 3'h7;
  // ==========================================================================
  // Pin positions inside a port
  localparam int PA  = 0;
  localparam int PB  = 1;
  localparam int PFS = 2;
  localparam int PCK = 3;
  localparam int PRX = 4;
  localparam int PTX = 5;
  // ==========================================================================
  // Mode register fields
  localparam int C_SYNC = 0;
  localparam int C_CKO  = 1;
  localparam int C_FSO  = 2;
  localparam int C_AO   = 3;
  localparam int C_BO   = 4;
  localparam int C_AF   = 5;
  localparam int C_BF   = 6;
  localparam int C_AV   = 7;
  localparam int C_BV   = 8;
  // ==========================================================================
  // Register map: kind in addr[5:3], port in addr[2]
  localparam logic [2:0] K_DIR  = 3'h0;
  localparam logic [2:0] K_FSEL = 3'h1;
  localparam logic [2:0] K_GOUT = 3'h2;
  localparam logic [2:0] K_PIN  = 3'h3;
  localparam logic [2:0] K_CTRL = 3'h4;
  localparam logic [2:0] K_TX   = 3'h5;
  localparam logic [2:0] K_RX   = 3'h6;
  localparam logic [2:0] K_STAT = 3'h7;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // ==========================================================================
  // State
  typedef struct packed {
    logic [5:0]            dir;
    logic [5:0]            fsel;
    logic [5:0]            gout;
    logic [8:0]            ctrl;
    logic [2:0][7:0]       thold;
    logic [2:0][7:0]       tsh;
    logic [7:0]            rsh;
    logic [7:0]            rword;
    logic [3:0]            tcnt;
    logic [3:0]            rcnt;
    logic [5:0]            s1;
    logic [5:0]            s2;
    logic [5:0]            s3;
    logic [5:0]            flt;
    logic                  tcq;
    logic                  rcq;
    logic [5:0]            po;
    logic [5:0]            poe;
  } ssp_port_t;

  typedef struct packed {
    ssp_port_t [1:0] pt;
    logic [1:0]      ls1;
    logic [1:0]      ls2;
    logic [1:0]      ls3;
    logic [1:0]      lflt;
    logic            awr;
    logic            wr;
    logic            arr;
    logic            awg;
    logic            wg;
    logic [7:0]      aa;
    logic [31:0]     wd;
    logic [3:0]      ws;
    logic            bv;
    logic [1:0]      br;
    logic            rv;
    logic [31:0]     rd;
    logic [1:0]      rr;
  } ssp_state_t;

  typedef struct packed {
    logic       sck;
    logic       fs;
    logic [2:0] bc;
  } ssp_lnk_t;
endpackage : ssp_pkg

//--- logic/ssp_top.sv
// Two serial ports sharing general purpose pins, registers on AXI4-Lite.
// Assumes pins resolved outside from o/oe; link_clk runs free.
`timescale 1ns/1ps
module ssp_top (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  link_clk,
  input  wire logic [1:0][5:0]       pin_i,
  output logic      [1:0][5:0]       pin_o,
  output logic      [1:0][5:0]       pin_oe,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  ssp_pkg::ssp_state_t st_reg;
  ssp_pkg::ssp_state_t st_next;
  ssp_pkg::ssp_lnk_t   lk_reg;
  ssp_pkg::ssp_lnk_t   lk_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // ==========================================================================
  // Link domain: internal bit clock and frame sync
  // Halving link_clk keeps each half of the bit clock far above three phases
  always_comb
  begin
    lk_next = lk_reg;
    lk_next.sck = !lk_reg.sck;
    if (lk_reg.sck)
    begin
      lk_next.bc = lk_reg.bc + 3'h1;
      lk_next.fs = (lk_next.bc == ssp_pkg::LBC_LAST);
    end
  end

  always_ff @(posedge link_clk or negedge rst_b)
  begin
    if (!rst_b)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  // ==========================================================================
  // System domain
  always_comb
  begin
    ssp_pkg::ssp_port_t cur;
    ssp_pkg::ssp_port_t nx;
    logic        tck;
    logic        tfs;
    logic        rck;
    logic        rfs;
    logic        tr;
    logic        rr;
    logic        rf;
    logic        isy;
    logic        wp;
    logic [31:0] rv;
    cur = '0;
    nx = '0;
    tck = 1'b0;
    tfs = 1'b0;
    rck = 1'b0;
    rfs = 1'b0;
    tr = 1'b0;
    rr = 1'b0;
    rf = 1'b0;
    isy = 1'b0;
    wp = 1'b0;
    rv = '0;
    st_next = st_reg;
    // Link levels cross through three stages; s1 feeds only s2
    st_next.ls1 = {lk_reg.sck, lk_reg.fs};
    st_next.ls2 = st_reg.ls1;
    st_next.ls3 = st_reg.ls2;
    if (st_reg.ls2 == st_reg.ls3)
      st_next.lflt = st_reg.ls3;
    for (int p = 0; p < ssp_pkg::NPORT; p++)
    begin
      cur = st_reg.pt[p];
      nx = cur;
      nx.s1 = pin_i[p];
      nx.s2 = cur.s1;
      nx.s3 = cur.s2;
      nx.flt = ((cur.s2 ~^ cur.s3) & cur.s3) | ((cur.s2 ^ cur.s3) & cur.flt);
      isy = cur.ctrl[ssp_pkg::C_SYNC];
      // Clock and frame sources; a glitch shorter than two cycles never reaches here
      tck = cur.ctrl[ssp_pkg::C_CKO] ? st_reg.lflt[1] : cur.flt[ssp_pkg::PCK];
      tfs = cur.ctrl[ssp_pkg::C_FSO] ? st_reg.lflt[0] : cur.flt[ssp_pkg::PFS];
      if (isy)
      begin
        rck = tck;
        rfs = tfs;
      end
      else
      begin
        rck = cur.ctrl[ssp_pkg::C_AO] ? st_reg.lflt[1] : cur.flt[ssp_pkg::PA];
        rfs = cur.ctrl[ssp_pkg::C_BO] ? st_reg.lflt[0] : cur.flt[ssp_pkg::PB];
      end
      tr = tck & !cur.tcq;
      rr = rck & !cur.rcq;
      rf = !rck & cur.rcq;
      nx.tcq = tck;
      nx.rcq = rck;
      // Transmit: frame sync at a rising edge reloads all three lanes
      if (!cur.fsel[ssp_pkg::PTX])
        nx.tcnt = '0;
      else if (tr)
      begin
        if (tfs)
        begin
          nx.tsh = cur.thold;
          nx.tcnt = ssp_pkg::WORD;
        end
        else if (cur.tcnt != '0)
        begin
          for (int l = 0; l < ssp_pkg::NLANE; l++)
            nx.tsh[l] = {cur.tsh[l][6:0], 1'b0};
          nx.tcnt = cur.tcnt - ssp_pkg::LAST;
        end
      end
      // Receive: sample on falling edges after a frame sync
      if (!cur.fsel[ssp_pkg::PRX])
        nx.rcnt = '0;
      else if (rr && rfs)
        nx.rcnt = ssp_pkg::WORD;
      else if (rf && cur.rcnt != '0)
      begin
        nx.rsh = {cur.rsh[6:0], cur.flt[ssp_pkg::PRX]};
        nx.rcnt = cur.rcnt - ssp_pkg::LAST;
        if (cur.rcnt == ssp_pkg::LAST)
          nx.rword = {cur.rsh[6:0], cur.flt[ssp_pkg::PRX]};
      end
      // Pin drive: general purpose unless the select bit is set
      nx.po = cur.gout;
      nx.poe = cur.dir;
      if (cur.fsel[ssp_pkg::PA])
      begin
        if (!isy)
        begin
          nx.poe[ssp_pkg::PA] = cur.ctrl[ssp_pkg::C_AO];
          nx.po[ssp_pkg::PA] = st_reg.lflt[1];
        end
        else if (cur.ctrl[ssp_pkg::C_AF])
        begin
          nx.poe[ssp_pkg::PA] = cur.ctrl[ssp_pkg::C_AO];
          nx.po[ssp_pkg::PA] = cur.ctrl[ssp_pkg::C_AV];
        end
        else
        begin
          nx.poe[ssp_pkg::PA] = 1'b1;
          nx.po[ssp_pkg::PA] = nx.tsh[1][7];
        end
      end
      if (cur.fsel[ssp_pkg::PB])
      begin
        if (!isy)
        begin
          nx.poe[ssp_pkg::PB] = cur.ctrl[ssp_pkg::C_BO];
          nx.po[ssp_pkg::PB] = st_reg.lflt[0];
        end
        else if (cur.ctrl[ssp_pkg::C_BF])
        begin
          nx.poe[ssp_pkg::PB] = cur.ctrl[ssp_pkg::C_BO];
          nx.po[ssp_pkg::PB] = cur.ctrl[ssp_pkg::C_BV];
        end
        else
        begin
          nx.poe[ssp_pkg::PB] = 1'b1;
          nx.po[ssp_pkg::PB] = nx.tsh[2][7];
        end
      end
      if (cur.fsel[ssp_pkg::PFS])
      begin
        nx.poe[ssp_pkg::PFS] = cur.ctrl[ssp_pkg::C_FSO];
        nx.po[ssp_pkg::PFS] = st_reg.lflt[0];
      end
      if (cur.fsel[ssp_pkg::PCK])
      begin
        nx.poe[ssp_pkg::PCK] = cur.ctrl[ssp_pkg::C_CKO];
        nx.po[ssp_pkg::PCK] = st_reg.lflt[1];
      end
      if (cur.fsel[ssp_pkg::PRX])
      begin
        nx.poe[ssp_pkg::PRX] = 1'b0;
        nx.po[ssp_pkg::PRX] = 1'b0;
      end
      if (cur.fsel[ssp_pkg::PTX])
      begin
        nx.poe[ssp_pkg::PTX] = (nx.tcnt != '0);
        nx.po[ssp_pkg::PTX] = nx.tsh[0][7];
      end
      st_next.pt[p] = nx;
    end
    // ========================================================================
    // AXI4-Lite write: address and data in either order
    if (st_reg.awr && s_axi_awvalid)
    begin
      st_next.awg = 1'b1;
      st_next.aa = s_axi_awaddr;
    end
    if (st_reg.wr && s_axi_wvalid)
    begin
      st_next.wg = 1'b1;
      st_next.wd = s_axi_wdata;
      st_next.ws = s_axi_wstrb;
    end
    if (st_reg.bv && s_axi_bready)
      st_next.bv = 1'b0;
    if (st_reg.awg && st_reg.wg && !st_reg.bv)
    begin
      st_next.awg = 1'b0;
      st_next.wg = 1'b0;
      st_next.bv = 1'b1;
      st_next.br = (st_reg.aa[7:6] != 2'h0) ? ssp_pkg::RESP_ERR : ssp_pkg::RESP_OK;
      wp = st_reg.aa[2];
      cur = st_next.pt[wp];
      if (st_reg.aa[7:6] == 2'h0)
      begin
        case (st_reg.aa[5:3])
          ssp_pkg::K_DIR:  cur.dir   = 6'(merge(32'(cur.dir), st_reg.wd, st_reg.ws));
          ssp_pkg::K_FSEL: cur.fsel  = 6'(merge(32'(cur.fsel), st_reg.wd, st_reg.ws));
          ssp_pkg::K_GOUT: cur.gout  = 6'(merge(32'(cur.gout), st_reg.wd, st_reg.ws));
          ssp_pkg::K_CTRL: cur.ctrl  = 9'(merge(32'(cur.ctrl), st_reg.wd, st_reg.ws));
          ssp_pkg::K_TX:   cur.thold = 24'(merge(32'(cur.thold), st_reg.wd, st_reg.ws));
          // Read-only kinds accept the write but change nothing
          default:         cur = st_next.pt[wp];
        endcase
      end
      st_next.pt[wp] = cur;
    end
    st_next.awr = !st_next.awg && !st_next.bv;
    st_next.wr = !st_next.wg && !st_next.bv;
    // ========================================================================
    // AXI4-Lite read: answer right after the address is taken
    if (st_reg.rv && s_axi_rready)
      st_next.rv = 1'b0;
    if (st_reg.arr && s_axi_arvalid)
    begin
      cur = st_reg.pt[s_axi_araddr[2]];
      case (s_axi_araddr[5:3])
        ssp_pkg::K_DIR:  rv = 32'(cur.dir);
        ssp_pkg::K_FSEL: rv = 32'(cur.fsel);
        ssp_pkg::K_GOUT: rv = 32'(cur.gout);
        ssp_pkg::K_PIN:  rv = 32'(cur.flt);
        ssp_pkg::K_CTRL: rv = 32'(cur.ctrl);
        ssp_pkg::K_TX:   rv = 32'(cur.thold);
        ssp_pkg::K_RX:   rv = 32'(cur.rword);
        default:         rv = 32'({cur.rcnt != '0, cur.tcnt != '0, cur.flt[1:0]});
      endcase
      st_next.rv = 1'b1;
      st_next.rd = (s_axi_araddr[7:6] != 2'h0) ? '0 : rv;
      st_next.rr = (s_axi_araddr[7:6] != 2'h0) ? ssp_pkg::RESP_ERR : ssp_pkg::RESP_OK;
    end
    st_next.arr = !st_next.rv;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign s_axi_awready = st_reg.awr;
  assign s_axi_wready  = st_reg.wr;
  assign s_axi_bvalid  = st_reg.bv;
  assign s_axi_bresp   = st_reg.br;
  assign s_axi_arready = st_reg.arr;
  assign s_axi_rvalid  = st_reg.rv;
  assign s_axi_rdata   = st_reg.rd;
  assign s_axi_rresp   = st_reg.rr;
  assign pin_o         = {st_reg.pt[1].po, st_reg.pt[0].po};
  assign pin_oe        = {st_reg.pt[1].poe, st_reg.pt[0].poe};

  // ==========================================================================
  // Checks
  generate
    for (genvar g = 0; g < ssp_pkg::NPORT; g++)
    begin : g_port
      AST_RESET_INPUT: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> pin_oe[g] == '0)
        else $error("pins not inputs after reset");
      AST_GPIO_DIR: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PFS] == 1'b0
        |=> pin_oe[g][ssp_pkg::PFS] == $past(st_reg.pt[g].dir[ssp_pkg::PFS]))
        else $error("gpio direction not followed");
      AST_FS_DIR: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PFS]
        |=> pin_oe[g][ssp_pkg::PFS] == $past(st_reg.pt[g].ctrl[ssp_pkg::C_FSO]))
        else $error("frame sync direction wrong");
      AST_SCK_DIR: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PCK] && st_reg.pt[g].ctrl[ssp_pkg::C_CKO]
        |=> pin_oe[g][ssp_pkg::PCK] && pin_o[g][ssp_pkg::PCK] == $past(st_reg.lflt[1]))
        else $error("bit clock output wrong");
      AST_A_ASYNC: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PA] && !st_reg.pt[g].ctrl[ssp_pkg::C_SYNC]
        |=> pin_oe[g][ssp_pkg::PA] == $past(st_reg.pt[g].ctrl[ssp_pkg::C_AO]))
        else $error("control pin a async direction wrong");
      AST_B_SYNC_TX: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PB] && st_reg.pt[g].ctrl[ssp_pkg::C_SYNC]
        && !st_reg.pt[g].ctrl[ssp_pkg::C_BF] |=> pin_oe[g][ssp_pkg::PB])
        else $error("control pin b not driving lane 2");
      AST_RXD_INPUT: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].fsel[ssp_pkg::PRX] |=> !pin_oe[g][ssp_pkg::PRX])
        else $error("receive pin driven");
      AST_TXD_ACTIVE: assert property (@(posedge clk) disable iff (!rst_b)
        pin_oe[g][ssp_pkg::PTX] && $past(st_reg.pt[g].fsel[ssp_pkg::PTX])
        |-> st_reg.pt[g].tcnt != '0 && pin_o[g][ssp_pkg::PTX] == st_reg.pt[g].tsh[0][7])
        else $error("transmit pin not from shift register");
      AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(st_reg.pt[g].flt) |-> ((st_reg.pt[g].flt ^ $past(st_reg.pt[g].flt))
        & $past(st_reg.pt[g].s2 ^ st_reg.pt[g].s3)) == 6'h00)
        else $error("filtered pin changed without agreement");
      AST_RX_SYNC_SRC: assert property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].ctrl[ssp_pkg::C_SYNC] && !st_reg.pt[g].ctrl[ssp_pkg::C_FSO]
        && !st_reg.pt[g].ctrl[ssp_pkg::C_CKO] && st_reg.pt[g].fsel[ssp_pkg::PRX]
        && st_reg.pt[g].flt[ssp_pkg::PFS] && st_reg.pt[g].flt[ssp_pkg::PCK] && !st_reg.pt[g].rcq
        |=> st_reg.pt[g].rcnt == ssp_pkg::WORD)
        else $error("receiver ignored shared frame sync");

      COV_TX_LOAD: cover property (@(posedge clk) disable iff (!rst_b)
        st_reg.pt[g].tcnt == ssp_pkg::WORD);
      COV_RX_WORD: cover property (@(posedge clk) disable iff (!rst_b)
        $changed(st_reg.pt[g].rword));
    end
  endgenerate

  COV_WRITE: cover property (@(posedge clk) disable iff (!rst_b)
    s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (@(posedge clk) disable iff (!rst_b)
    s_axi_rvalid && s_axi_rready);
endmodule : ssp_top

//--- verification/ssp_peer.sv
// Serial peer model for one port: drives clock, frame sync and data pins.
// Assumes the bench resolves each pin from all enables and feeds it back on lvl.
`timescale 1ns/1ps
module ssp_peer (
  input  wire logic       clk,
  input  wire logic [5:0] lvl,
  output logic      [5:0] p_o,
  output logic      [5:0] p_oe
);
  // ==========================================================================
  // Timing
  // Half bit period in system clocks, kept at or above the three-phase minimum
  localparam int HALF = 5;
  initial
  begin
    p_o  = 6'h00;
    p_oe = 6'h00;
  end
  task automatic wt;
    repeat (HALF) @(posedge clk);
  endtask : wt
  // ==========================================================================
  // Pin drive; undriven pins fall to the bench's changing pattern
  task automatic drive(input logic [5:0] v, input logic [5:0] en);
    @(posedge clk);
    p_o  <= v;
    p_oe <= en;
  endtask : drive
  // Clock stays low outside the frame so no stray edge reaches the port
  task automatic send(input int ck, input int fs, input int dt, input logic [7:0] w);
    // Idle levels settle through the port's filter before the frame opens
    wt();
    p_o[fs] <= 1'b1;
    wt();
    for (int i = 7; i >= 0; i--)
    begin
      p_o[ck] <= 1'b1;
      p_o[dt] <= w[i];
      wt();
      p_o[ck] <= 1'b0;
      p_o[fs] <= 1'b0;
      wt();
    end
  endtask : send
  // ==========================================================================
  // Capture of the three transmit lanes, MSB first
  task automatic wait_ck(input logic v);
    logic pc;
    pc = lvl[3];
    @(negedge clk);
    while (!(pc === ~v && lvl[3] === v))
    begin
      pc = lvl[3];
      @(negedge clk);
    end
  endtask : wait_ck
  task automatic capture(output logic [23:0] got);
    logic pf;
    pf = 1'b0;
    // Pins are read mid-cycle, never in the step where the port updates them
    @(negedge clk);
    // Frame sync is judged mid-bit, away from the clock edge it could race
    while (pf !== 1'b1)
    begin
      wait_ck(1'b0);
      pf = lvl[2];
    end
    wait_ck(1'b1);
    for (int i = 7; i >= 0; i--)
    begin
      wait_ck(1'b0);
      got[i]      = lvl[5];
      got[8 + i]  = lvl[0];
      got[16 + i] = lvl[1];
    end
  endtask : capture
endmodule : ssp_peer

//--- verification/test_sync_serial_port_pins.sv
// Self-checking bench for the dual serial port pin block.
// Assumes ssp_top, ssp_pkg and ssp_peer; one peer model per port.
`timescale 1ns/1ps
module test_sync_serial_port_pins;
  // ==========================================================================
  // Signals
  logic             clk;
  logic             rst_b;
  logic             link_clk;
  logic [1:0][5:0]  pin_i;
  logic [1:0][5:0]  pin_o;
  logic [1:0][5:0]  pin_oe;
  logic [1:0][5:0]  peer_o;
  logic [1:0][5:0]  peer_oe;
  logic             pat;
  logic [7:0]       s_axi_awaddr;
  logic             s_axi_awvalid;
  logic             s_axi_awready;
  logic [31:0]      s_axi_wdata;
  logic             s_axi_wvalid;
  logic             s_axi_wready;
  logic [1:0]       s_axi_bresp;
  logic             s_axi_bvalid;
  logic             s_axi_bready;
  logic [7:0]       s_axi_araddr;
  logic             s_axi_arvalid;
  logic             s_axi_arready;
  logic [31:0]      s_axi_rdata;
  logic [1:0]       s_axi_rresp;
  logic             s_axi_rvalid;
  logic             s_axi_rready;
  int               n_errors;
  int               checked;
  int               cyc;
  // Undriven pins toggle every cycle so a stale level can never pass
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & peer_oe & peer_o) | (~pin_oe & ~peer_oe & {12{pat}});
  ssp_top uut (
    .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  ssp_peer u_peer0 (.clk(clk), .lvl(pin_i[0]), .p_o(peer_o[0]), .p_oe(peer_oe[0]));
  ssp_peer u_peer1 (.clk(clk), .lvl(pin_i[1]), .p_o(peer_o[1]), .p_oe(peer_oe[1]));
  // ==========================================================================
  // Clocks and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge clk)
  begin
    pat <= ~pat;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // ==========================================================================
  // Helpers
  task automatic stop_test;
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] ad(input logic [2:0] k, input logic p);
    return {2'b00, k, p, 2'b00};
  endfunction : ad
  // Write channels are released one by one as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w  = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    // Ready is judged mid-cycle, so the edge that takes a channel is known before it
    while (!(aw && w))
    begin
      @(negedge clk);
      aw = aw || s_axi_awready === 1'b1;
      w  = w || s_axi_wready === 1'b1;
      @(posedge clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    chk(s_axi_rdata, ed);
    @(posedge clk);
  endtask : rd
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk({20'h0, pin_oe}, 32'h0);
    rd(ad(ssp_pkg::K_DIR, 1'b0), 32'h0, ssp_pkg::RESP_OK);
    rd(ad(ssp_pkg::K_FSEL, 1'b1), 32'h0, ssp_pkg::RESP_OK);
  endtask : t_reset
  task automatic t_gpio;
    wr(ad(ssp_pkg::K_DIR, 1'b0), 32'h3f, ssp_pkg::RESP_OK);
    wr(ad(ssp_pkg::K_GOUT, 1'b0), 32'h2a, ssp_pkg::RESP_OK);
    repeat (3) @(posedge clk);
    chk({26'h0, pin_oe[0]}, 32'h3f);
    chk({26'h0, pin_o[0]}, 32'h2a);
    u_peer1.drive(6'h15, 6'h3f);
    repeat (8) @(posedge clk);
    rd(ad(ssp_pkg::K_PIN, 1'b1), 32'h15, ssp_pkg::RESP_OK);
    rd(ad(ssp_pkg::K_STAT, 1'b1), 32'h1, ssp_pkg::RESP_OK);
    chk({26'h0, pin_oe[1]}, 32'h0);
    rd(8'h40, 32'h0, ssp_pkg::RESP_ERR);
    wr(8'hc4, 32'h3f, ssp_pkg::RESP_ERR);
    wr(ad(ssp_pkg::K_DIR, 1'b0), 32'h0, ssp_pkg::RESP_OK);
  endtask : t_gpio
  task automatic t_flags;
    wr(ad(ssp_pkg::K_CTRL, 1'b0), 32'hf9, ssp_pkg::RESP_OK);
    wr(ad(ssp_pkg::K_FSEL, 1'b0), 32'h03, ssp_pkg::RESP_OK);
    repeat (3) @(posedge clk);
    chk({30'h0, pin_oe[0][1:0]}, 32'h3);
    chk({30'h0, pin_o[0][1:0]}, 32'h1);
  endtask : t_flags
  task automatic t_tx;
    logic [23:0] got;
    wr(ad(ssp_pkg::K_TX, 1'b0), 32'h3c5aa5, ssp_pkg::RESP_OK);
    wr(ad(ssp_pkg::K_CTRL, 1'b0), 32'h07, ssp_pkg::RESP_OK);
    wr(ad(ssp_pkg::K_FSEL, 1'b0), 32'h3f, ssp_pkg::RESP_OK);
    u_peer0.capture(got);
    chk({8'h0, got}, 32'h3c5aa5);
    chk({26'h0, pin_oe[0]}, 32'h2f);
  endtask : t_tx
  task automatic t_rx_sync;
    wr(ad(ssp_pkg::K_CTRL, 1'b0), 32'h01, ssp_pkg::RESP_OK);
    u_peer0.drive(6'h00, 6'h1c);
    u_peer0.send(ssp_pkg::PCK, ssp_pkg::PFS, ssp_pkg::PRX, 8'h96);
    repeat (6) @(posedge clk);
    rd(ad(ssp_pkg::K_RX, 1'b0), 32'h96, ssp_pkg::RESP_OK);
    chk({29'h0, pin_oe[0][4:2]}, 32'h0);
  endtask : t_rx_sync
  task automatic t_rx_async;
    wr(ad(ssp_pkg::K_CTRL, 1'b0), 32'h00, ssp_pkg::RESP_OK);
    u_peer0.drive(6'h00, 6'h13);
    u_peer0.send(ssp_pkg::PA, ssp_pkg::PB, ssp_pkg::PRX, 8'h3c);
    repeat (6) @(posedge clk);
    rd(ad(ssp_pkg::K_RX, 1'b0), 32'h3c, ssp_pkg::RESP_OK);
    chk({30'h0, pin_oe[0][1:0]}, 32'h0);
  endtask : t_rx_async
  // ==========================================================================
  // Main sequence
  initial
  begin
    n_errors      = 0;
    checked       = 0;
    cyc           = 0;
    pat           = 1'b0;
    rst_b         = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b1;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b1;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_gpio();
    t_flags();
    t_tx();
    t_rx_sync();
    t_rx_async();
    stop_test();
  end
endmodule : test_sync_serial_port_pins
